// File: hw/bstap_top.sv
// Boundary-scan test access port: controller, instruction, bypass, identification and
// boundary registers, and the core-side pin multiplexer they steer.
// Assumes the tester drives test clock, mode select, data in and the reset pin, and that
// the system supplies its functional pin values in the core domain and the raw pin levels asynchronously.
`default_nettype none
`include "bstap_map.svh"

module bstap_top
    import bstap_pkg::*;
#(
    // Identification value; arbitrary, with the mandatory low bit set.
    parameter logic [`BSTAP_IDR_WIDTH-1:0] ID_VALUE = 32'h1234_5001
) (
    // Core clock and power-up reset.
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Test port pins from the tester.
    input wire logic test_clock_pin_in,
    input wire logic test_reset_low_pin_in,
    input wire logic test_data_in_pin_in,
    input wire logic test_mode_select_pin_in,
    // Test port data out pin, three-state.
    output logic test_data_out_pin_out,
    output logic test_data_out_pin_oe_out,
    // Functional pin values from the system logic, core domain.
    input wire bstap_pins_type core_func_in,
    // Raw levels seen on the digital pins, asynchronous.
    input wire logic [`BSTAP_BSR_WIDTH-1:0] pin_level_in,
    // Values driven onto the digital pins.
    output bstap_pins_type pin_drive_out,
    // Current instruction as seen by the core domain.
    output logic [`BSTAP_IR_WIDTH-1:0] test_instr_out
);

    // ------------------------------------------------------------------------
    // Reset of the test clock domain
    // ------------------------------------------------------------------------

    // Either the power-up reset or the low reset pin forces Test-Logic-Reset at once.
    logic tap_reset;
    assign tap_reset = reset_in | ~test_reset_low_pin_in;
    // The reset pin acts at once, without synchronisers, so its release is
    // expected while the test clock is at rest.

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    bstap_rise_type rise;
    bstap_rise_type next_rise;
    bstap_fall_type fall;
    bstap_fall_type next_fall;
    bstap_core_type core;
    bstap_core_type next_core;

    // Decoded register selection for the current instruction.
    logic sel_bsr;
    logic sel_idr;

    // Short names for the two serial inputs, sampled on the rising edge.
    logic tms;
    logic tdi;

    assign tms = test_mode_select_pin_in;
    assign tdi = test_data_in_pin_in;

    // Boundary for sample/preload and external test, identification for its code,
    // and the one-bit bypass for everything else, including unused codes.
    always_comb begin
        sel_bsr = (fall.ir_cur == `BSTAP_IR_EXTEST) || (fall.ir_cur == `BSTAP_IR_SAMPLE);
        sel_idr = (fall.ir_cur == `BSTAP_IR_IDCODE);
    end

    // ------------------------------------------------------------------------
    // Rising edge logic: controller and shift paths
    // ------------------------------------------------------------------------

    // Mode select is sampled only here, so the tester must settle it after the falling edge.
    always_comb begin
        next_rise = rise;
        // Pin levels cross from outside through two stages before capture.
        next_rise.pin_sync1 = pin_level_in;
        next_rise.pin_sync2 = rise.pin_sync1;
        // Next state from mode select at this edge.
        unique case (rise.state)
            BSTAP_TLR: begin
                next_rise.state = tms ? BSTAP_TLR : BSTAP_RTI;
            end
            BSTAP_RTI: begin
                next_rise.state = tms ? BSTAP_SEL_DR : BSTAP_RTI;
            end

            // Data scan column.
            BSTAP_SEL_DR: begin
                next_rise.state = tms ? BSTAP_SEL_IR : BSTAP_CAP_DR;
            end
            BSTAP_CAP_DR: begin
                next_rise.state = tms ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
            end
            BSTAP_SHIFT_DR: begin
                next_rise.state = tms ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
            end
            BSTAP_EXIT1_DR: begin
                next_rise.state = tms ? BSTAP_UPD_DR : BSTAP_PAUSE_DR;
            end
            BSTAP_PAUSE_DR: begin
                next_rise.state = tms ? BSTAP_EXIT2_DR : BSTAP_PAUSE_DR;
            end
            BSTAP_EXIT2_DR: begin
                next_rise.state = tms ? BSTAP_UPD_DR : BSTAP_SHIFT_DR;
            end
            BSTAP_UPD_DR: begin
                next_rise.state = tms ? BSTAP_SEL_DR : BSTAP_RTI;
            end

            // Instruction scan column; its top returns to reset.
            BSTAP_SEL_IR: begin
                next_rise.state = tms ? BSTAP_TLR : BSTAP_CAP_IR;
            end
            BSTAP_CAP_IR: begin
                next_rise.state = tms ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
            end
            BSTAP_SHIFT_IR: begin
                next_rise.state = tms ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
            end
            BSTAP_EXIT1_IR: begin
                next_rise.state = tms ? BSTAP_UPD_IR : BSTAP_PAUSE_IR;
            end
            BSTAP_PAUSE_IR: begin
                next_rise.state = tms ? BSTAP_EXIT2_IR : BSTAP_PAUSE_IR;
            end
            BSTAP_EXIT2_IR: begin
                next_rise.state = tms ? BSTAP_UPD_IR : BSTAP_SHIFT_IR;
            end
            BSTAP_UPD_IR: begin
                next_rise.state = tms ? BSTAP_SEL_DR : BSTAP_RTI;
            end
        endcase

        // Register actions; every state not named below leaves all shifters alone,
        // which covers idle, select, pause, exit and update states.
        unique case (rise.state)
            BSTAP_CAP_IR: begin
                next_rise.ir_shift = `BSTAP_IR_CAPTURE;
            end
            BSTAP_SHIFT_IR: begin
                // Parallel instruction and data registers are untouched here.
                next_rise.ir_shift = {tdi, rise.ir_shift[`BSTAP_IR_WIDTH-1:1]};
            end

            // Data registers: only the selected one loads or moves.
            BSTAP_CAP_DR: begin
                if (sel_bsr) begin
                    next_rise.bsr_shift = rise.pin_sync2;
                end else if (sel_idr) begin
                    next_rise.idr_shift = ID_VALUE;
                end else begin
                    next_rise.bypass = `BSTAP_BYPASS_CAPTURE;
                end
            end

            BSTAP_SHIFT_DR: begin
                // Only the selected register moves; the others keep their contents.
                if (sel_bsr) begin
                    next_rise.bsr_shift = {tdi, rise.bsr_shift[`BSTAP_BSR_WIDTH-1:1]};
                end else if (sel_idr) begin
                    next_rise.idr_shift = {tdi, rise.idr_shift[`BSTAP_IDR_WIDTH-1:1]};
                end else begin
                    next_rise.bypass = tdi;
                end
            end
            default: begin
                next_rise.bypass = rise.bypass;
            end
        endcase
    end

    // Rising edge registers of the test clock domain.
    always_ff @(posedge test_clock_pin_in or posedge tap_reset) begin
        if (tap_reset) begin
            rise <= '{state: BSTAP_TLR, default: '0};
        end else begin
            rise <= next_rise;
        end
    end

    // ------------------------------------------------------------------------
    // Falling edge logic: data out, instruction and update latches
    // ------------------------------------------------------------------------

    // Data out and the latches move on the falling edge, half a period after the shift,
    // so the tester sees a settled bit at the next rising edge.
    always_comb begin
        next_fall = fall;
        // Parked low and undriven unless a shift state drives it, so the
        // tester sees a steady line between scans.
        next_fall.tdo_en = 1'b0;
        next_fall.tdo = 1'b0;
        unique case (rise.state)
            BSTAP_SHIFT_IR: begin
                next_fall.tdo_en = 1'b1;
                next_fall.tdo = rise.ir_shift[0];
            end
            BSTAP_SHIFT_DR: begin
                next_fall.tdo_en = 1'b1;
                if (sel_bsr) begin
                    next_fall.tdo = rise.bsr_shift[0];
                end else if (sel_idr) begin
                    next_fall.tdo = rise.idr_shift[0];
                end else begin
                    next_fall.tdo = rise.bypass;
                end
            end

            BSTAP_TLR: begin
                // Announce the identification instruction on every falling edge here:
                // a test reset clears the toggle, and without a fresh edge the core
                // could keep an older instruction.
                next_fall.ir_cur = `BSTAP_IR_IDCODE;
                next_fall.upd_toggle = ~fall.upd_toggle;
            end

            // Update states toggle so the core takes the new words.
            BSTAP_UPD_IR: begin
                next_fall.ir_cur = rise.ir_shift;
                next_fall.upd_toggle = ~fall.upd_toggle;
            end
            BSTAP_UPD_DR: begin
                // Only registers with a parallel output latch take the shifted value.
                if (sel_bsr) begin
                    next_fall.bsr_latch = rise.bsr_shift;
                end
                if (sel_idr) begin
                    next_fall.idr_latch = rise.idr_shift;
                end
                next_fall.upd_toggle = ~fall.upd_toggle;
            end
            default: begin
                next_fall.ir_cur = fall.ir_cur;
            end
        endcase
    end

    // Falling edge registers of the test clock domain.
    always_ff @(negedge test_clock_pin_in or posedge tap_reset) begin
        if (tap_reset) begin
            fall <= '{ir_cur: `BSTAP_IR_IDCODE, default: '0};
        end else begin
            fall <= next_fall;
        end
    end

    // ------------------------------------------------------------------------
    // Core domain: crossing and pin multiplexer
    // ------------------------------------------------------------------------

    // The instruction and boundary latch are words, so they are not synchronised bit by
    // bit: a toggle announces a change and the words are taken only after it has crossed.
    // They are stable then, because the next change needs a whole new scan sequence.
    // The limitation is that a test clock about as fast as the core clock or faster
    // could alter them before the core takes them.
    always_comb begin
        next_core = core;
        // Two stages for the toggle, a third to spot its edge.
        next_core.tog_sync1 = fall.upd_toggle;
        next_core.tog_sync2 = core.tog_sync1;
        next_core.tog_seen = core.tog_sync2;
        if (core.tog_sync2 != core.tog_seen) begin
            next_core.ir = fall.ir_cur;
            next_core.bsr = fall.bsr_latch;
        end

        // Normal operation unless an instruction takes over the pins.
        next_core.pin_out = core_func_in.value;
        next_core.pin_oe = core_func_in.enable;
        unique case (core.ir)
            `BSTAP_IR_EXTEST, `BSTAP_IR_CLAMP: begin
                next_core.pin_out = core.bsr;
                next_core.pin_oe = '1;
            end
            `BSTAP_IR_HIGHZ: begin
                next_core.pin_oe = '0;
            end
            default: begin
                next_core.pin_out = core_func_in.value;
            end
        endcase
    end

    // Core domain registers.
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            core <= '{ir: `BSTAP_IR_IDCODE, default: '0};
        end else begin
            core <= next_core;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Serial data out and its enable, from the falling edge flops.
    assign test_data_out_pin_out = fall.tdo;
    assign test_data_out_pin_oe_out = fall.tdo_en;

    // Pin drive and instruction, from the core domain flops.
    assign pin_drive_out.value = core.pin_out;
    assign pin_drive_out.enable = core.pin_oe;
    assign test_instr_out = core.ir;

endmodule

`default_nettype wire

// File: hw/bstap_map.svh
// Constants of the boundary-scan test access port: instruction codes, widths, capture values.
// Assumes it is included by the package and the top module by its bare name.
`ifndef BSTAP_MAP_SVH
`define BSTAP_MAP_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define BSTAP_IR_WIDTH 3
`define BSTAP_IDR_WIDTH 32
`define BSTAP_BSR_WIDTH 8

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define BSTAP_IR_EXTEST 3'h0
`define BSTAP_IR_IDCODE 3'h1
`define BSTAP_IR_SAMPLE 3'h2
`define BSTAP_IR_CLAMP 3'h3
`define BSTAP_IR_HIGHZ 3'h4
`define BSTAP_IR_BYPASS 3'h7

// ----------------------------------------------------------------------------
// Capture values
// ----------------------------------------------------------------------------
`define BSTAP_IR_CAPTURE 3'h1
`define BSTAP_BYPASS_CAPTURE 1'h0

`endif

// File: hw/bstap_pkg.sv
// Types of the boundary-scan test access port: controller states and per-domain state.
// Assumes bstap_map.svh is on the include path.
`default_nettype none
`include "bstap_map.svh"

package bstap_pkg;

    // ------------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        BSTAP_TLR = 4'h0,
        BSTAP_RTI = 4'h1,
        BSTAP_SEL_DR = 4'h2,
        BSTAP_CAP_DR = 4'h3,
        BSTAP_SHIFT_DR = 4'h4,
        BSTAP_EXIT1_DR = 4'h5,
        BSTAP_PAUSE_DR = 4'h6,
        BSTAP_EXIT2_DR = 4'h7,
        BSTAP_UPD_DR = 4'h8,
        BSTAP_SEL_IR = 4'h9,
        BSTAP_CAP_IR = 4'hA,
        BSTAP_SHIFT_IR = 4'hB,
        BSTAP_EXIT1_IR = 4'hC,
        BSTAP_PAUSE_IR = 4'hD,
        BSTAP_EXIT2_IR = 4'hE,
        BSTAP_UPD_IR = 4'hF
    } bstap_state_type;

    // ------------------------------------------------------------------------
    // State kept on the rising test clock edge
    // ------------------------------------------------------------------------
    typedef struct packed {
        bstap_state_type state;
        logic [`BSTAP_IR_WIDTH-1:0] ir_shift;
        logic bypass;
        logic [`BSTAP_IDR_WIDTH-1:0] idr_shift;
        logic [`BSTAP_BSR_WIDTH-1:0] bsr_shift;
        logic [`BSTAP_BSR_WIDTH-1:0] pin_sync1;
        logic [`BSTAP_BSR_WIDTH-1:0] pin_sync2;
    } bstap_rise_type;

    // ------------------------------------------------------------------------
    // State kept on the falling test clock edge
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic tdo;
        logic tdo_en;
        logic [`BSTAP_IR_WIDTH-1:0] ir_cur;
        logic [`BSTAP_IDR_WIDTH-1:0] idr_latch;
        logic [`BSTAP_BSR_WIDTH-1:0] bsr_latch;
        logic upd_toggle;
    } bstap_fall_type;

    // ------------------------------------------------------------------------
    // State kept in the core clock domain
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic tog_sync1;
        logic tog_sync2;
        logic tog_seen;
        logic [`BSTAP_IR_WIDTH-1:0] ir;
        logic [`BSTAP_BSR_WIDTH-1:0] bsr;
        logic [`BSTAP_BSR_WIDTH-1:0] pin_out;
        logic [`BSTAP_BSR_WIDTH-1:0] pin_oe;
    } bstap_core_type;

    // Driven pin pair as handed to the pads.
    typedef struct packed {
        logic [`BSTAP_BSR_WIDTH-1:0] value;
        logic [`BSTAP_BSR_WIDTH-1:0] enable;
    } bstap_pins_type;

endpackage

`default_nettype wire

// File: sim/bstap_tester.sv
// Model of the outside tester that drives the test port pins.
// Assumes each scan starts with the controller in Run-Test-Idle.
`default_nettype none

module bstap_tester (
    // Pins driven toward the device.
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    output logic trst_n_out,
    // Pins read back from the device.
    input wire logic tdo_in,
    input wire logic tdo_oe_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // The clock rests low between frames, as a real tester leaves it.
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
        trst_n_out = 1'b1;
    end

    // One 80 ns period; inputs change while the clock is low, data out is read on the rise.
    task automatic tick(input logic tms, input logic tdi, output logic seen);
        tms_out = tms;
        tdi_out = tdi;
        #23;
        tck_out = 1'b1;
        seen = tdo_oe_in ? tdo_in : 1'bx; // An undriven line reads as unknown.
        #40;
        tck_out = 1'b0;
        #17;
    endtask

    // Full scan of n bits, least significant first, with an optional pause.
    task automatic scan(input logic is_ir, input logic [31:0] din, input logic [5:0] n,
                        input logic [5:0] pause_at, output logic [31:0] dout);
        logic seen;
        int i;
        dout = 32'h0;
        tick(1'b1, 1'b0, seen);
        if (is_ir) begin
            tick(1'b1, 1'b0, seen);
        end
        tick(1'b0, 1'b0, seen);
        tick(1'b0, 1'b0, seen);
        for (i = 0; i < n; i++) begin
            tick(i == n - 1 || i == pause_at - 1, din[i], seen);
            dout[i] = seen;
            if (i == pause_at - 1 && i != n - 1) begin
                tick(1'b0, 1'b1, seen);
                tick(1'b0, 1'b0, seen);
                tick(1'b1, 1'b1, seen);
                tick(1'b0, 1'b0, seen);
            end
        end
        tick(1'b1, 1'b0, seen);
        tick(1'b0, 1'b0, seen);
        tdi_out = ~din[n - 1]; // Released line no longer shows the last bit.
    endtask

    // Test reset pulse with the clock at rest.
    task automatic pulse_reset();
        trst_n_out = 1'b0;
        #400;
        trst_n_out = 1'b1;
        #50;
    endtask
endmodule

`default_nettype wire

// File: sim/bstap_top_props.sv
// Checker for the test access port, watching only the top module's ports.
// Assumes bstap_pkg is compiled first; bound to bstap_top at the foot.
`default_nettype none
`include "bstap_map.svh"

module bstap_top_props
    import bstap_pkg::*;
(
    // Clocks and resets.
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic test_clock_pin_in,
    input wire logic test_reset_low_pin_in,
    // Serial pins.
    input wire logic test_data_in_pin_in,
    input wire logic test_mode_select_pin_in,
    input wire logic test_data_out_pin_out,
    input wire logic test_data_out_pin_oe_out,
    // Core side.
    input wire bstap_pins_type core_func_in,
    input wire logic [`BSTAP_BSR_WIDTH-1:0] pin_level_in,
    input wire bstap_pins_type pin_drive_out,
    input wire logic [`BSTAP_IR_WIDTH-1:0] test_instr_out
);
    // Next state, four bits per state, for mode select low and high.
    localparam logic [63:0] NEXT_LO = 64'h1BDD_BBA1_4664_4311;
    localparam logic [63:0] NEXT_HI = 64'h2FEF_CC02_8785_5920;
    logic tap_rst;
    logic [3:0] st;
    logic [3:0] prev_st;
    logic [2:0] ir_sh;
    logic [2:0] ir_cur;
    assign tap_rst = reset_in | ~test_reset_low_pin_in;

    // Shadow controller, so the checks need not look inside the design.
    always_ff @(posedge test_clock_pin_in or posedge tap_rst) begin
        if (tap_rst) begin
            st <= BSTAP_TLR;
            prev_st <= BSTAP_TLR;
            ir_sh <= `BSTAP_IR_CAPTURE;
        end else begin
            prev_st <= st;
            st <= test_mode_select_pin_in ? NEXT_HI[{st, 2'h0} +: 4] : NEXT_LO[{st, 2'h0} +: 4];
            if (st == BSTAP_CAP_IR) begin
                ir_sh <= `BSTAP_IR_CAPTURE;
            end else if (st == BSTAP_SHIFT_IR) begin
                ir_sh <= {test_data_in_pin_in, ir_sh[2:1]};
            end
        end
    end

    // Shadow current instruction, latched on the falling edge.
    always_ff @(negedge test_clock_pin_in or posedge tap_rst) begin
        if (tap_rst) begin
            ir_cur <= `BSTAP_IR_IDCODE;
        end else if (st == BSTAP_TLR) begin
            ir_cur <= `BSTAP_IR_IDCODE;
        end else if (st == BSTAP_UPD_IR) begin
            ir_cur <= ir_sh;
        end
    end

    a_oe_in_shift: assert property (@(negedge test_clock_pin_in) disable iff (tap_rst)
        1'b1 |=> test_data_out_pin_oe_out == ($past(st) inside {BSTAP_SHIFT_IR, BSTAP_SHIFT_DR}))
        else $error("data out enable outside shift states");
    a_ir_capture: assert property (@(negedge test_clock_pin_in) disable iff (tap_rst)
        st == BSTAP_SHIFT_IR && prev_st == BSTAP_CAP_IR |=> test_data_out_pin_out == 1'b1)
        else $error("captured instruction bit wrong");
    a_out_fall: assert property (@(posedge core_clk_in) disable iff (reset_in)
        $changed(test_data_out_pin_out) || $changed(test_data_out_pin_oe_out)
        |-> !test_clock_pin_in)
        else $error("data out moved while test clock high");
    a_trst_quiet: assert property (@(posedge core_clk_in) disable iff (reset_in)
        !test_reset_low_pin_in ##1 !test_reset_low_pin_in
        |-> !test_data_out_pin_oe_out && !test_data_out_pin_out)
        else $error("data out driven during test reset");
    a_instr_model: assert property (@(posedge core_clk_in) disable iff (reset_in)
        $changed(test_instr_out) |-> test_instr_out == ir_cur)
        else $error("instruction differs from shifted value");
    a_drive_func: assert property (@(posedge core_clk_in) disable iff (reset_in)
        test_instr_out inside {`BSTAP_IR_IDCODE, `BSTAP_IR_SAMPLE, `BSTAP_IR_BYPASS}
        |=> pin_drive_out == $past(core_func_in))
        else $error("pins not functional");
    a_drive_highz: assert property (@(posedge core_clk_in) disable iff (reset_in)
        test_instr_out == `BSTAP_IR_HIGHZ |=> pin_drive_out.enable == 8'h00)
        else $error("pins driven while floated");
    a_clamp_steady: assert property (@(posedge core_clk_in) disable iff (reset_in)
        test_instr_out == `BSTAP_IR_CLAMP [*2]
        |=> pin_drive_out.enable == 8'hFF && $stable(pin_drive_out.value))
        else $error("clamped pins moved");
endmodule

bind bstap_top bstap_top_props u_props (.core_clk_in, .reset_in, .test_clock_pin_in,
    .test_reset_low_pin_in, .test_data_in_pin_in, .test_mode_select_pin_in,
    .test_data_out_pin_out, .test_data_out_pin_oe_out, .core_func_in, .pin_level_in,
    .pin_drive_out, .test_instr_out);

`default_nettype wire

// File: sim/test_boundary_scan_tap_controller.sv
// Self-checking bench for the test access port with an outside tester model.
// Assumes bstap_pkg, bstap_top, bstap_tester and the checker are compiled first.
`default_nettype none
`include "bstap_map.svh"

module test_boundary_scan_tap_controller
    import bstap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------------------
    // Cases: instruction, scan length, data in, data out, pins after.
    // --------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] code;
        logic [5:0] len;
        logic [31:0] din;
        logic [31:0] dout;
        bstap_pins_type drive;
    } bstap_case_type;
    localparam logic [31:0] ID_CODE = 32'h2468_ACE1; // Arbitrary value, low bit set.
    localparam bstap_pins_type FUNC = 16'h960F;
    localparam bstap_case_type ROWS [6] = '{
        '{`BSTAP_IR_SAMPLE, 6'h08, 32'h3C, 32'hA5, FUNC},
        '{`BSTAP_IR_EXTEST, 6'h08, 32'h5A, 32'hA5, 16'h5AFF},
        '{`BSTAP_IR_CLAMP, 6'h08, 32'hC3, 32'h86, 16'h5AFF},
        '{`BSTAP_IR_HIGHZ, 6'h08, 32'hC3, 32'h86, 16'h9600},
        '{`BSTAP_IR_BYPASS, 6'h08, 32'h81, 32'h02, FUNC},
        '{`BSTAP_IR_IDCODE, 6'h20, 32'h0, ID_CODE, FUNC}};

    logic core_clk_in;
    logic reset_in;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdo_oe;
    bstap_pins_type core_func_in;
    bstap_pins_type pin_drive_out;
    logic [7:0] pin_level_in;
    logic [2:0] test_instr_out;
    logic [31:0] dout;
    logic seen;
    int err_total;
    int tests_run;

    bstap_top #(.ID_VALUE(ID_CODE)) DUT (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .test_clock_pin_in(tck), .test_reset_low_pin_in(trst_n), .test_data_in_pin_in(tdi),
        .test_mode_select_pin_in(tms), .test_data_out_pin_out(tdo),
        .test_data_out_pin_oe_out(tdo_oe), .core_func_in(core_func_in),
        .pin_level_in(pin_level_in), .pin_drive_out(pin_drive_out),
        .test_instr_out(test_instr_out));
    bstap_tester u_tester (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
        .tdo_in(tdo), .tdo_oe_in(tdo_oe));

    always #5 core_clk_in = ~core_clk_in;

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_pins(input bstap_pins_type got, input bstap_pins_type exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The instruction needs a few core edges to cross from the test clock.
    task automatic settle();
        repeat (8) @(posedge core_clk_in);
        #1;
    endtask

    task automatic load_ir(input logic [2:0] code, input logic [5:0] pause_at);
        u_tester.scan(1'b1, 32'(code), 6'h03, pause_at, dout);
        check_word(dout, 32'h1);
        settle();
        check_word(32'(test_instr_out), 32'(code));
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog well above the few tens of microseconds the run needs.
    initial begin
        #300000;
        err_total++;
        give_verdict();
    end

    initial begin
        core_clk_in = 1'b0;
        reset_in = 1'b1;
        core_func_in = FUNC;
        pin_level_in = 8'hA5;
        err_total = 0;
        tests_run = 0;
        repeat (6) @(posedge core_clk_in);
        #1 reset_in = 1'b0;
        settle();
        check_word(32'(test_instr_out), 32'(`BSTAP_IR_IDCODE));
        u_tester.tick(1'b0, 1'b0, seen);
        foreach (ROWS[i]) begin
            load_ir(ROWS[i].code, 6'h00);
            u_tester.scan(1'b0, ROWS[i].din, ROWS[i].len, 6'h00, dout);
            check_word(dout, ROWS[i].dout);
            settle();
            check_pins(pin_drive_out, ROWS[i].drive);
        end
        // Scans paused midway must lose no bit.
        load_ir(`BSTAP_IR_BYPASS, 6'h02);
        load_ir(`BSTAP_IR_IDCODE, 6'h01);
        u_tester.scan(1'b0, 32'h0, 6'h20, 6'h05, dout);
        check_word(dout, ID_CODE);
        // Mode select held high from idle falls back to reset.
        load_ir(`BSTAP_IR_BYPASS, 6'h00);
        repeat (3) u_tester.tick(1'b1, 1'b0, seen);
        settle();
        check_word(32'(test_instr_out), 32'(`BSTAP_IR_IDCODE));
        u_tester.tick(1'b0, 1'b0, seen);
        // Test reset pin in mid-run.
        load_ir(`BSTAP_IR_BYPASS, 6'h00);
        u_tester.pulse_reset();
        u_tester.tick(1'b1, 1'b0, seen);
        u_tester.tick(1'b0, 1'b0, seen);
        settle();
        check_word(32'(test_instr_out), 32'(`BSTAP_IR_IDCODE));
        // Power-up reset in mid-run with pins floated.
        load_ir(`BSTAP_IR_HIGHZ, 6'h00);
        reset_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        #1 reset_in = 1'b0;
        settle();
        check_word(32'(test_instr_out), 32'(`BSTAP_IR_IDCODE));
        check_pins(pin_drive_out, FUNC);
        give_verdict();
    end
endmodule

`default_nettype wire
